// ===== srs_reg_bank.sv
// Reset-state register bank: status, diagnosis, interrupt, system and
// physical-layer control words, each set or kept per reset kind.
// Assumes reset-kind pulses and wake causes come from the mode sequencer
// on ref_clk; analogue status levels arrive asynchronously.
//
// What this block does
// R1: Reset source and power-on flag per kind
// R2: CAN wake flag: clear, set, or keep
// R3: LIN wake flag: clear, set, or keep
// R4: Edge wake flag: clear, set, or keep
// R5: Enable status zero, else CAN state
// R6: Diagnosis fixed at power-on, then live
// R7: Power-on clears interrupt enables only
// R8: Power-on, start-up and restart clear pending interrupts; fail-safe keeps them
// R9: Reset length short, long after restart/fail-safe
// R10: Inhibit/limp enable per kind and level
// R11: Inhibit/limp level low at power-on, fail-safe
// R12: Regulator two control automatic on power-on, fail-safe
// R13: Partial networking off per kind, CAN wake
// R14: Physical layer power-on values, then kept
// R15: Emulated enable high only without CAN failure
// R16: Each reset kind applied same cycle
`timescale 1ns/1ps
`default_nettype none

module srs_reg_bank
  import srs_pkg::*;
#(
  parameter int INT_W = 8
) (
  input wire logic ref_clk,
  input wire logic srst,
  // Reset kind indications, one-cycle pulses
  input wire logic rst_power_on,
  input wire logic rst_start_up,
  input wire logic rst_restart,
  input wire logic rst_fail_safe,
  // Cause of the reset, valid beside a reset pulse
  input wire logic [3:0] rst_source_in,
  input wire logic wake_by_can,
  input wire logic wake_by_lin,
  input wire logic wake_by_edge,
  // Asynchronous status levels
  input wire logic ground_shift_in,
  input wire logic [3:0] can_failure_in,
  input wire logic [1:0] lin_failure_in,
  input wire logic reg3_ok_in,
  input wire logic reg2_ok_in,
  input wire logic reg1_ok_in,
  input wire logic [1:0] can_mode_in,
  input wire logic wake_level_in,
  input wire logic temp_warning_in,
  input wire logic sw_dev_mode_in,
  // Enable function level from mode logic
  input wire logic en_function,
  // Interrupt events, one-cycle pulses
  input wire logic [INT_W-1:0] int_event,
  // Register port
  input wire logic [`SRS_ADDR_W-1:0] reg_addr,
  input wire logic [`SRS_DATA_W-1:0] reg_wdata,
  input wire logic reg_wr,
  input wire logic reg_rd,
  output logic [`SRS_DATA_W-1:0] reg_rdata,
  // Control fields driven to the chip
  output logic en_pin,
  output logic power_on_flag,
  output logic [3:0] reset_source_field,
  output logic [INT_W-1:0] int_enable,
  output logic [INT_W-1:0] int_pending,
  output logic ground_shift_threshold,
  output logic reset_length_sel,
  output logic [1:0] reg3_control,
  output logic reg1_current_monitor_sel,
  output logic wake_enable,
  output logic wake_sample_sel,
  output logic inhibit_limp_enable,
  output logic inhibit_limp_level,
  output logic reg2_control,
  output logic can_partial_net_ctrl,
  output logic can_offline_time_ctrl,
  output logic can_transmitter_ctrl,
  output logic can_rx_ctrl,
  output logic can_mode_ctrl,
  output logic can_split_ctrl,
  output logic lin_mode_ctrl,
  output logic lin_slope_ctrl,
  output logic lin_driver_ctrl,
  output logic lin_wake_enable,
  output logic lin_transmitter_ctrl,
  output logic error_pin_emulation
);

  localparam int LIVE_W = 15;

  // Only the implemented interrupt bits can ever be set
  localparam logic [11:0] INT_MASK = 12'((13'h1 << INT_W) - 13'h1);

  // Power-on image of the whole state
  localparam srs_state_t POR_STATE = '{
    reset_source_field: `SRS_SRC_POR,
    can_wake_flag: 1'b0,
    lin_wake_flag: 1'b0,
    edge_wake_flag: 1'b0,
    wake_level_flag: 1'b0,
    temp_warning_flag: 1'b0,
    sw_dev_mode_flag: 1'b0,
    enable_status_bit: 1'b0,
    power_on_flag: 1'b1,
    live: 1'b0,
    diag: `SRS_DIAG_POR,
    int_en: 12'h000,
    int_pend: 12'h000,
    sys_cfg: `SRS_SYS_POR,
    phy_cfg: `SRS_PHY_POR,
    error_pin_emulation: 1'b0,
    en_pin: 1'b0,
    rdata: 12'h000
  };

  // Refuse interrupt widths the 12-bit words cannot hold
  if (INT_W < 1 || INT_W > 12) begin : g_chk
    $error("srs_reg_bank INT_W must be 1 to 12");
  end

  srs_state_t q, d;
  srs_rst_kind_t kind;
  logic [LIVE_W-1:0] live_async;
  logic [LIVE_W-1:0] live_sync;
  logic [11:0] diag_live;
  logic can_ok;
  logic [11:0] int_ev12;
  logic [11:0] pend_clr;
  logic [11:0] rd_val;

  // Analogue levels are not on ref_clk, so they pass two flops
  assign live_async = {
    sw_dev_mode_in,
    temp_warning_in,
    wake_level_in,
    can_mode_in,
    reg1_ok_in,
    reg2_ok_in,
    reg3_ok_in,
    lin_failure_in,
    can_failure_in,
    ground_shift_in
  };

  srs_sync #(
    .W(LIVE_W)
  ) u_sync (
    .ref_clk(ref_clk),
    .srst(srst),
    .async_in(live_async),
    .sync_out(live_sync)
  );

  assign diag_live = live_sync[11:0];
  assign can_ok = (diag_live[`SRS_DG_CANF_HI:`SRS_DG_CANF_LO] == 4'h0); // R15

  // Power-on outranks fail-safe, which outranks restart and start-up
  always_comb begin
    if (rst_power_on) begin
      kind = RK_POR;
    end else if (rst_fail_safe) begin
      kind = RK_FAILSAFE;
    end else if (rst_restart) begin
      kind = RK_RESTART;
    end else if (rst_start_up) begin
      kind = RK_STARTUP;
    end else begin
      kind = RK_NONE;
    end
  end

  // Widen events and write-one-to-clear mask to the word size
  always_comb begin
    int_ev12 = 12'h000;
    int_ev12[INT_W-1:0] = int_event;
    pend_clr = 12'h000;
    if (reg_wr && reg_addr == `SRS_OFS_INT_PEND) begin
      pend_clr = reg_wdata & INT_MASK;
    end
  end

  // Read mux; unmapped offsets read zero
  always_comb begin
    rd_val = 12'h000;
    case (reg_addr)
      `SRS_OFS_STATUS: begin
        rd_val[`SRS_ST_SRC_LO +: 4] = q.reset_source_field;
        rd_val[`SRS_ST_CAN_WAKE] = q.can_wake_flag;
        rd_val[`SRS_ST_LIN_WAKE] = q.lin_wake_flag;
        rd_val[`SRS_ST_EDGE_WAKE] = q.edge_wake_flag;
        rd_val[`SRS_ST_WAKE_LVL] = q.wake_level_flag;
        rd_val[`SRS_ST_TEMP_WARN] = q.temp_warning_flag;
        rd_val[`SRS_ST_SW_DEV] = q.sw_dev_mode_flag;
        rd_val[`SRS_ST_ENABLE] = q.enable_status_bit;
        rd_val[`SRS_ST_PWR_ON] = q.power_on_flag;
      end
      `SRS_OFS_DIAG: rd_val = q.diag;
      `SRS_OFS_INT_EN: rd_val = q.int_en;
      `SRS_OFS_INT_PEND: rd_val = q.int_pend;
      `SRS_OFS_SYS_CFG: rd_val = q.sys_cfg;
      `SRS_OFS_PHY_CFG: rd_val = q.phy_cfg;
      `SRS_OFS_MODE: rd_val[`SRS_MD_EMUL] = q.error_pin_emulation;
      default: rd_val = 12'h000;
    endcase
  end

  // Next state: live tracking, software access, then reset kinds on top
  always_comb begin
    d = q;
    d.rdata = reg_rd ? rd_val : 12'h000;

    // Wake level and development mode always show the present level
    d.wake_level_flag = live_sync[12];
    d.sw_dev_mode_flag = live_sync[14];

    // Diagnosis and warning stay frozen until the first start-up/restart
    if (q.live) begin
      d.diag = diag_live; // R6
      d.temp_warning_flag = live_sync[13];
    end

    // Enable pin mirrors the CAN state only under emulation
    d.en_pin = q.live & (q.error_pin_emulation ? can_ok : en_function); // R15
    d.enable_status_bit = d.en_pin;

    // Events win over a clear in the same cycle
    d.int_pend = (q.int_pend & ~pend_clr) | (int_ev12 & q.int_en & INT_MASK);

    // Software writes; status and diagnosis words are read-only
    if (reg_wr) begin
      case (reg_addr)
        `SRS_OFS_INT_EN: d.int_en = reg_wdata & INT_MASK;
        `SRS_OFS_SYS_CFG: d.sys_cfg = reg_wdata;
        `SRS_OFS_PHY_CFG: d.phy_cfg = reg_wdata;
        `SRS_OFS_MODE: d.error_pin_emulation = reg_wdata[`SRS_MD_EMUL];
        default: d.sys_cfg = d.sys_cfg;
      endcase
    end

    // Reset kinds override software in the very cycle they are seen
    case (kind) // R16
      RK_POR: begin
        d = POR_STATE; // R1 R2 R3 R4 R5 R6 R7 R8 R9 R10 R11 R12 R13 R14
        d.rdata = reg_rd ? rd_val : 12'h000;
        d.wake_level_flag = live_sync[12];
        d.sw_dev_mode_flag = live_sync[14];
      end
      RK_FAILSAFE: begin
        d.sys_cfg[`SRS_SC_RST_LEN] = 1'b1; // R9
        d.sys_cfg[`SRS_SC_IL_EN] = 1'b1; // R10
        d.sys_cfg[`SRS_SC_IL_LVL] = 1'b0; // R11
        d.phy_cfg[`SRS_PC_REG2] = 1'b0; // R12
        d.phy_cfg[`SRS_PC_PNET] = 1'b0; // R13
      end
      RK_RESTART: begin
        // Only the four legal restart codes are kept
        if (rst_source_in == `SRS_SRC_POR || rst_source_in == `SRS_SRC_RS_A ||
            rst_source_in == `SRS_SRC_RS_B || rst_source_in == `SRS_SRC_RS_C) begin
          d.reset_source_field = rst_source_in; // R1
        end else begin
          d.reset_source_field = `SRS_SRC_POR; // R1
        end
        d.live = 1'b1; // R6
        d.enable_status_bit = q.error_pin_emulation & can_ok; // R5
        d.en_pin = q.error_pin_emulation & can_ok;
        d.int_pend = 12'h000; // R8
        d.sys_cfg[`SRS_SC_RST_LEN] = 1'b1; // R9
        if (q.sys_cfg[`SRS_SC_IL_LVL]) begin
          d.sys_cfg[`SRS_SC_IL_EN] = 1'b0; // R10
        end
      end
      RK_STARTUP: begin
        // A forbidden start-up code leaves the previous source standing
        if (rst_source_in != `SRS_SRC_BAN_START) begin
          d.reset_source_field = rst_source_in; // R1
        end
        if (wake_by_can) begin
          d.can_wake_flag = 1'b1; // R2
          d.phy_cfg[`SRS_PC_PNET] = 1'b0; // R13
        end
        if (wake_by_lin) begin
          d.lin_wake_flag = 1'b1; // R3
        end
        if (wake_by_edge) begin
          d.edge_wake_flag = 1'b1; // R4
        end
        d.live = 1'b1; // R6
        d.enable_status_bit = q.error_pin_emulation & can_ok; // R5
        d.en_pin = q.error_pin_emulation & can_ok;
        d.int_pend = 12'h000; // R8
      end
      RK_NONE: begin
        d.live = q.live;
      end
      default: begin
        d = q;
      end
    endcase
  end

  // Logic reset lands on the power-on image as well
  always_ff @(posedge ref_clk) begin
    if (srst) begin
      q <= POR_STATE;
    end else begin
      q <= d;
    end
  end

  // Outputs straight from the state flops
  assign reg_rdata = q.rdata;
  assign en_pin = q.en_pin;
  assign power_on_flag = q.power_on_flag;
  assign reset_source_field = q.reset_source_field;
  assign int_enable = q.int_en[INT_W-1:0];
  assign int_pending = q.int_pend[INT_W-1:0];
  assign error_pin_emulation = q.error_pin_emulation;

  // System configuration fields
  assign ground_shift_threshold = q.sys_cfg[0];
  assign reset_length_sel = q.sys_cfg[`SRS_SC_RST_LEN];
  assign reg3_control = q.sys_cfg[3:2];
  assign reg1_current_monitor_sel = q.sys_cfg[4];
  assign wake_enable = q.sys_cfg[5];
  assign wake_sample_sel = q.sys_cfg[6];
  assign inhibit_limp_enable = q.sys_cfg[`SRS_SC_IL_EN];
  assign inhibit_limp_level = q.sys_cfg[`SRS_SC_IL_LVL];

  // Physical layer control fields
  assign reg2_control = q.phy_cfg[`SRS_PC_REG2];
  assign can_partial_net_ctrl = q.phy_cfg[`SRS_PC_PNET];
  assign can_offline_time_ctrl = q.phy_cfg[2];
  assign can_transmitter_ctrl = q.phy_cfg[3];
  assign can_rx_ctrl = q.phy_cfg[4];
  assign can_mode_ctrl = q.phy_cfg[5];
  assign can_split_ctrl = q.phy_cfg[6];
  assign lin_mode_ctrl = q.phy_cfg[7];
  assign lin_slope_ctrl = q.phy_cfg[8];
  assign lin_driver_ctrl = q.phy_cfg[9];
  assign lin_wake_enable = q.phy_cfg[10];
  assign lin_transmitter_ctrl = q.phy_cfg[11];

endmodule : srs_reg_bank

`default_nettype wire

// ===== srs_consts.svh
// Offsets, field positions, reset values for the reset-state register bank.
// Assumes it is included by bare name from the package, compiled ahead of the bank.
`ifndef SRS_CONSTS_SVH
`define SRS_CONSTS_SVH

// Register offsets on the plain register port
`define SRS_ADDR_W 3
`define SRS_DATA_W 12
`define SRS_OFS_STATUS 3'h0
`define SRS_OFS_DIAG 3'h1
`define SRS_OFS_INT_EN 3'h2
`define SRS_OFS_INT_PEND 3'h3
`define SRS_OFS_SYS_CFG 3'h4
`define SRS_OFS_PHY_CFG 3'h5
`define SRS_OFS_MODE 3'h6

// Status word fields
`define SRS_ST_SRC_LO 0
`define SRS_ST_CAN_WAKE 4
`define SRS_ST_LIN_WAKE 5
`define SRS_ST_EDGE_WAKE 6
`define SRS_ST_WAKE_LVL 7
`define SRS_ST_TEMP_WARN 8
`define SRS_ST_SW_DEV 9
`define SRS_ST_ENABLE 10
`define SRS_ST_PWR_ON 11

// Diagnosis word fields
`define SRS_DG_CANF_LO 1
`define SRS_DG_CANF_HI 4

// System configuration fields
`define SRS_SC_RST_LEN 1
`define SRS_SC_IL_EN 7
`define SRS_SC_IL_LVL 8

// Physical layer control fields
`define SRS_PC_REG2 0
`define SRS_PC_PNET 1

// Mode word field
`define SRS_MD_EMUL 0

// Reset values and reset source codes
`define SRS_DIAG_POR 12'h180
`define SRS_SYS_POR 12'h020
`define SRS_PHY_POR 12'h404
`define SRS_SRC_POR 4'h0
`define SRS_SRC_BAN_START 4'hc
`define SRS_SRC_RS_A 4'h2
`define SRS_SRC_RS_B 4'hc
`define SRS_SRC_RS_C 4'he

`endif

// ===== srs_pkg.sv
// Types shared by the reset-state register bank.
// Assumes srs_consts.svh is on the include path.
`include "srs_consts.svh"

package srs_pkg;

  // Reset kind after priority decode
  typedef enum logic [2:0] {
    RK_NONE,
    RK_POR,
    RK_FAILSAFE,
    RK_RESTART,
    RK_STARTUP
  } srs_rst_kind_t;

  // Whole state of the bank
  typedef struct packed {
    logic [3:0] reset_source_field;
    logic can_wake_flag;
    logic lin_wake_flag;
    logic edge_wake_flag;
    logic wake_level_flag;
    logic temp_warning_flag;
    logic sw_dev_mode_flag;
    logic enable_status_bit;
    logic power_on_flag;
    logic live;
    logic [11:0] diag;
    logic [11:0] int_en;
    logic [11:0] int_pend;
    logic [11:0] sys_cfg;
    logic [11:0] phy_cfg;
    logic error_pin_emulation;
    logic en_pin;
    logic [11:0] rdata;
  } srs_state_t;

endpackage : srs_pkg

// ===== srs_sync.sv
// Two-flop synchroniser for a bundle of unrelated status levels.
// Assumes each bit is a slow level; bits are not coherent with each other.
`timescale 1ns/1ps
`default_nettype none

module srs_sync #(
  parameter int W = 15
) (
  input wire logic ref_clk,
  input wire logic srst,
  input wire logic [W-1:0] async_in,
  output logic [W-1:0] sync_out
);

  typedef struct packed {
    logic [W-1:0] meta;
    logic [W-1:0] stable;
  } srs_sync_state_t;

  srs_sync_state_t q, d;

  // Refuse an empty bundle
  if (W < 1) begin : g_chk
    $error("srs_sync width must be at least one");
  end

  // First stage feeds only the second stage
  always_comb begin
    d.meta = async_in;
    d.stable = q.meta;
  end

  always_ff @(posedge ref_clk) begin
    if (srst) begin
      q <= '0;
    end else begin
      q <= d;
    end
  end

  assign sync_out = q.stable;

endmodule : srs_sync

`default_nettype wire

// ===== srs_reg_bank_asserts.sv
// Port checker for the reset-state register bank.
// Assumes one clock domain and a synchronous active-high reset.
`timescale 1ns/1ps
`default_nettype none
module srs_reg_bank_asserts #(
  parameter int INT_W = 8
) (
  input wire logic ref_clk,
  input wire logic srst,
  input wire logic rst_power_on,
  input wire logic rst_start_up,
  input wire logic rst_restart,
  input wire logic rst_fail_safe,
  input wire logic wake_by_can,
  input wire logic power_on_flag,
  input wire logic [3:0] reset_source_field,
  input wire logic [INT_W-1:0] int_enable,
  input wire logic [INT_W-1:0] int_pending,
  input wire logic reset_length_sel,
  input wire logic inhibit_limp_enable,
  input wire logic inhibit_limp_level,
  input wire logic reg2_control,
  input wire logic can_partial_net_ctrl,
  input wire logic can_offline_time_ctrl,
  input wire logic lin_wake_enable,
  input wire logic en_pin
);
  default clocking cb @(posedge ref_clk); endclocking
  default disable iff (srst);
  // Kinds after priority; a lower pulse beside a higher one is ignored
  wire fs_only = rst_fail_safe && !rst_power_on;
  wire rs_only = rst_restart && !rst_fail_safe && !rst_power_on;
  wire su_only = rst_start_up && !rst_restart && !rst_fail_safe && !rst_power_on;

  por_src_a: assert property (rst_power_on |=> reset_source_field == 4'h0 && power_on_flag)
    else $error("power-on source or flag wrong");
  pon_hold_a: assert property (!rst_power_on |=> power_on_flag == $past(power_on_flag))
    else $error("power-on flag moved without power-on");
  por_cfg_a: assert property (rst_power_on |=> !reset_length_sel && !en_pin
    && can_offline_time_ctrl && lin_wake_enable) else $error("power-on config wrong");
  por_int_a: assert property (rst_power_on |=> int_enable == '0 && int_pending == '0)
    else $error("power-on left interrupts");
  kind_pend_a: assert property ((su_only || rs_only || rst_power_on) |=> int_pending == '0)
    else $error("pending not cleared by reset kind");
  rs_src_a: assert property (rs_only |=> reset_source_field inside {4'h0, 4'h2, 4'hc, 4'he})
    else $error("restart source code illegal");
  rs_len_a: assert property ((rs_only || fs_only) |=> reset_length_sel)
    else $error("reset length not long");
  rs_il_a: assert property (rs_only && inhibit_limp_level |=> !inhibit_limp_enable)
    else $error("restart kept limp enable");
  fs_cfg_a: assert property (fs_only |=> inhibit_limp_enable && !inhibit_limp_level
    && !reg2_control && !can_partial_net_ctrl) else $error("fail-safe config wrong");
  su_pnet_a: assert property (su_only && wake_by_can |=> !can_partial_net_ctrl)
    else $error("partial networking kept after CAN wake");

  // Main scenarios reached
  su_c: cover property (su_only && wake_by_can);
  rs_c: cover property (rs_only && inhibit_limp_level);
  fs_c: cover property (fs_only);
endmodule : srs_reg_bank_asserts
`default_nettype wire

// ===== srs_mcu_model.sv
// Microcontroller model: master on the plain register port.
// Assumes read data stand only in the cycle after the read strobe.
`timescale 1ns/1ps
`default_nettype none
module srs_mcu_model (
  input wire logic ref_clk,
  output logic [2:0] reg_addr,
  output logic [11:0] reg_wdata,
  output logic reg_wr,
  output logic reg_rd,
  input wire logic [11:0] reg_rdata
);
  // Idle bus at time zero
  initial begin
    reg_addr = 3'h0;
    reg_wdata = 12'h000;
    reg_wr = 1'b0;
    reg_rd = 1'b0;
  end

  // One-cycle write; stale data inverted so a late sample shows up
  task automatic wr(input logic [2:0] a, input logic [11:0] d);
    @(posedge ref_clk);
    reg_addr <= a;
    reg_wdata <= d;
    reg_wr <= 1'b1;
    @(posedge ref_clk);
    reg_wr <= 1'b0;
    reg_wdata <= ~d;
  endtask : wr

  // One-cycle read, data taken in the following cycle
  task automatic rd(input logic [2:0] a, output logic [11:0] d);
    @(posedge ref_clk);
    reg_addr <= a;
    reg_rd <= 1'b1;
    @(posedge ref_clk);
    reg_rd <= 1'b0;
    #1;
    d = reg_rdata;
  endtask : rd
endmodule : srs_mcu_model
`default_nettype wire

// ===== tb.sv
// Testbench for the reset-state register bank, with a microcontroller model.
// Assumes the checker and model files are compiled first.
`timescale 1ns/1ps
`default_nettype none
module tb;
  logic ref_clk, srst, rst_power_on, rst_start_up, rst_restart, rst_fail_safe;
  logic [3:0] rst_source_in, can_failure_in, reset_source_field;
  logic wake_by_can, wake_by_lin, wake_by_edge, ground_shift_in, reg3_ok_in, reg2_ok_in;
  logic reg1_ok_in, wake_level_in, temp_warning_in, sw_dev_mode_in, en_function;
  logic [1:0] lin_failure_in, can_mode_in;
  logic [7:0] int_event, int_enable, int_pending;
  logic [2:0] reg_addr;
  logic [11:0] reg_wdata, reg_rdata, rv;
  logic reg_wr, reg_rd, en_pin, power_on_flag, reset_length_sel, inhibit_limp_enable;
  logic inhibit_limp_level, reg2_control, can_partial_net_ctrl, can_offline_time_ctrl;
  logic lin_wake_enable, error_pin_emulation;
  int fails = 0;
  int compares = 0;
  int cycles = 0;

  srs_reg_bank #(.INT_W(8)) i_dut (.ground_shift_threshold(), .reg3_control(),
    .reg1_current_monitor_sel(), .wake_enable(), .wake_sample_sel(), .can_transmitter_ctrl(),
    .can_rx_ctrl(), .can_mode_ctrl(), .can_split_ctrl(), .lin_mode_ctrl(), .lin_slope_ctrl(),
    .lin_driver_ctrl(), .lin_transmitter_ctrl(), .*);
  srs_mcu_model i_mcu (.*);

  initial begin
    ref_clk = 1'b0;
    forever #20 ref_clk = ~ref_clk;
  end

  task automatic print_verdict();
    $display("compares %0d fails %0d", compares, fails);
    if (fails == 0 && compares > 0) begin
      $display("All tests passed");
    end else begin
      $display("Some tests failed");
    end
    $finish;
  endtask : print_verdict

  task automatic chk(input logic [11:0] got, input logic [11:0] exp);
    compares++;
    if (got !== exp) begin
      fails++;
      $display("mismatch at %0t: got %h expected %h", $time, got, exp);
    end
  endtask : chk

  task automatic rchk(input logic [2:0] a, input logic [11:0] exp);
    i_mcu.rd(a, rv);
    chk(rv, exp);
  endtask : rchk

  // Kind bits: 8 power-on, 4 fail-safe, 2 restart, 1 start-up
  task automatic pulse(input logic [3:0] k, input logic [3:0] src, input logic [2:0] w);
    @(posedge ref_clk);
    {rst_power_on, rst_fail_safe, rst_restart, rst_start_up} <= k;
    rst_source_in <= src;
    {wake_by_can, wake_by_lin, wake_by_edge} <= w;
    @(posedge ref_clk);
    {rst_power_on, rst_fail_safe, rst_restart, rst_start_up} <= 4'h0;
    #1;
  endtask : pulse

  task automatic ev();
    @(posedge ref_clk);
    int_event <= 8'h01;
    @(posedge ref_clk);
    int_event <= 8'h00;
  endtask : ev

  // Live levels differ from the power-on image, so freezing shows
  task automatic t_por();
    rchk(3'h0, 12'h800);
    rchk(3'h1, 12'h180);
    rchk(3'h2, 12'h000);
    rchk(3'h3, 12'h000);
    rchk(3'h4, 12'h020);
    rchk(3'h5, 12'h404);
    rchk(3'h7, 12'h000);
    i_mcu.wr(3'h0, 12'hfff);
    rchk(3'h0, 12'h800);
  endtask : t_por

  task automatic t_startup();
    i_mcu.wr(3'h2, 12'h0ff);
    i_mcu.wr(3'h4, 12'h1a0);
    i_mcu.wr(3'h5, 12'h407);
    ev();
    rchk(3'h3, 12'h001);
    pulse(4'h1, 4'h3, 3'b110);
    rchk(3'h0, 12'h933);
    rchk(3'h3, 12'h000);
    rchk(3'h2, 12'h0ff);
    rchk(3'h4, 12'h1a0);
    rchk(3'h5, 12'h405);
    repeat (4) @(posedge ref_clk);
    rchk(3'h1, 12'h6c1);
    // Forbidden start-up code keeps the source, edge wake alone sets its flag
    pulse(4'h1, 4'hc, 3'b001);
    rchk(3'h0, 12'h973);
    rchk(3'h5, 12'h405);
  endtask : t_startup

  task automatic t_restart();
    logic [3:0] code [5] = '{4'h0, 4'h2, 4'hc, 4'he, 4'h5};
    logic [3:0] expv [5] = '{4'h0, 4'h2, 4'hc, 4'he, 4'h0};
    ev();
    for (int i = 0; i < 5; i++) begin
      pulse(4'h2, code[i], 3'b000);
      chk({8'h00, reset_source_field}, {8'h00, expv[i]});
    end
    chk({9'h000, reset_length_sel, inhibit_limp_enable, inhibit_limp_level}, 12'h005);
    rchk(3'h0, 12'h970);
    rchk(3'h3, 12'h000);
  endtask : t_restart

  task automatic t_failsafe();
    i_mcu.wr(3'h4, 12'h120);
    ev();
    i_mcu.wr(3'h5, 12'h407);
    pulse(4'h4, 4'h0, 3'b000);
    chk({7'h00, reset_length_sel, inhibit_limp_enable, inhibit_limp_level, reg2_control,
      can_partial_net_ctrl}, 12'h018);
    rchk(3'h2, 12'h0ff);
    // Fail-safe leaves pending alone; software clears it by writing one
    rchk(3'h3, 12'h001);
    i_mcu.wr(3'h3, 12'h001);
    rchk(3'h3, 12'h000);
  endtask : t_failsafe

  // Emulated enable follows the CAN failure field, with sync lag
  task automatic t_emul();
    // Without emulation the pin and status follow the enable function
    @(posedge ref_clk);
    en_function <= 1'b1;
    repeat (3) @(posedge ref_clk);
    #1;
    chk({11'h000, en_pin}, 12'h001);
    rchk(3'h0, 12'hd70);
    i_mcu.wr(3'h6, 12'h001);
    repeat (5) @(posedge ref_clk);
    #1;
    chk({11'h000, en_pin}, 12'h001);
    @(posedge ref_clk);
    can_failure_in <= 4'h3;
    repeat (5) @(posedge ref_clk);
    #1;
    chk({11'h000, en_pin}, 12'h000);
    rchk(3'h1, 12'h6c7);
  endtask : t_emul

  task automatic t_por2();
    pulse(4'h8, 4'h9, 3'b111);
    chk({11'h000, error_pin_emulation}, 12'h000);
    rchk(3'h0, 12'h800);
    rchk(3'h1, 12'h180);
    rchk(3'h2, 12'h000);
    rchk(3'h4, 12'h020);
    rchk(3'h5, 12'h404);
  endtask : t_por2

  // Hang guard, well above the expected run
  always @(posedge ref_clk) begin
    cycles++;
    if (cycles == 5000) begin
      fails++;
      print_verdict();
    end
  end

  initial begin
    srst = 1'b1;
    {rst_power_on, rst_start_up, rst_restart, rst_fail_safe} = 4'h0;
    rst_source_in = 4'h0;
    {wake_by_can, wake_by_lin, wake_by_edge} = 3'b000;
    {ground_shift_in, reg3_ok_in, reg2_ok_in, reg1_ok_in} = 4'b1101;
    can_failure_in = 4'h0;
    lin_failure_in = 2'h2;
    can_mode_in = 2'h1;
    {wake_level_in, temp_warning_in, sw_dev_mode_in, en_function} = 4'b0100;
    int_event = 8'h00;
    repeat (10) @(posedge ref_clk);
    srst <= 1'b0;
    t_por();
    t_startup();
    t_restart();
    t_failsafe();
    t_emul();
    t_por2();
    print_verdict();
  end
endmodule : tb

bind srs_reg_bank srs_reg_bank_asserts #(.INT_W(INT_W)) i_chk (.*);
`default_nettype wire
